// ---- cmpc_pkg.sv ----
// package of constants and helpers for the comparator control block
package cmpc_pkg;

  // register indices, byte address is four times the index
  localparam logic [2:0] IDX_CTRL  = 3'h0;
  localparam logic [2:0] IDX_INSEL = 3'h2;
  localparam logic [2:0] IDX_IEN   = 3'h6;
  localparam logic [2:0] IDX_STAT  = 3'h7;

  // comparator_control fields
  localparam int CTRL_EN   = 0;
  localparam int CTRL_HYS  = 1;
  localparam int CTRL_MODE = 4;
  localparam int CTRL_PAD_OUTPUT_ENABLE = 6;
  localparam int CTRL_RUNSB = 7;
  localparam logic [7:0] CTRL_MASK = 8'hF7;

  // input_select fields
  localparam int INSEL_NEG = 0;
  localparam int INSEL_POS = 3;
  localparam int INSEL_INV = 7;
  localparam logic [7:0] INSEL_MASK = 8'h9B;

  // interrupt_enable and comparator_status fields
  localparam int IEN_CMP   = 0;
  localparam int STAT_FLAG = 0;
  localparam int STAT_STATE = 4;

  // reset values
  localparam logic [7:0] REG_RESET = 8'h00;

  // edge_mode codes
  localparam logic [1:0] MODE_ANY  = 2'h0;
  localparam logic [1:0] MODE_RSVD = 2'h1;
  localparam logic [1:0] MODE_FALL = 2'h2;
  localparam logic [1:0] MODE_RISE = 2'h3;

  // negative_select codes
  localparam logic [1:0] NEG_PIN0 = 2'h0;
  localparam logic [1:0] NEG_PIN1 = 2'h1;
  localparam logic [1:0] NEG_VREF = 2'h2;
  localparam logic [1:0] NEG_DAC  = 2'h3;

  // status latency in clock cycles, two sync stages plus the register
  localparam int STATE_DELAY = 3;

  // index of an aligned word address, with a mapped flag
  function automatic logic [3:0] cmpc_decode(input logic [7:0] addr);
    logic ok;
    ok = (addr[1:0] == 2'h0) && (addr[7:5] == 3'h0) &&
         (addr[4:2] == IDX_CTRL || addr[4:2] == IDX_INSEL ||
          addr[4:2] == IDX_IEN || addr[4:2] == IDX_STAT);
    return {ok, addr[4:2]};
  endfunction

  // does this edge pair match the selected edge mode
  function automatic logic cmpc_hit(input logic [1:0] mode, input logic rise, input logic fall);
    logic h;
    h = 1'b0;
    unique case (mode)
      MODE_ANY:  h = rise | fall;
      MODE_RSVD: h = 1'b0;
      MODE_FALL: h = fall;
      MODE_RISE: h = rise;
    endcase
    return h;
  endfunction

endpackage

// ---- cmpc_sync.sv ----
// two-stage synchroniser for the asynchronous comparator output
`timescale 1ns/1ps
module cmpc_sync
(
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // asynchronous level in, synchronised level out
  input  wire logic async_in,
  output logic      sync_out
);

  logic meta_q;
  logic meta_d;
  logic sync_q;
  logic sync_d;

  // first stage feeds only the second stage
  always_comb
  begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end
    else
    begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;

endmodule

// ---- cmpc_top.sv ----
// comparator control: apb registers, sync, edge flag, pad, event and irq
//
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps
module cmpc_top
  import cmpc_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // analog core
  input  wire logic        cmp_raw,
  output logic             ana_enable,
  output logic [1:0]       positive_select,
  output logic [1:0]       negative_select,
  output logic [1:0]       hysteresis_select,
  // sleep state
  input  wire logic        standby_sleep,
  input  wire logic        powerdown_sleep,
  // pad, event and interrupt
  output logic             pad_out,
  output logic             pad_oe,
  output logic             event_out,
  output logic             irq
);

  ////////////////////////////////////////////////////////////////////////////
  // registers and next values

  logic [7:0]  ctrl_q, ctrl_d;
  logic [7:0]  insel_q, insel_d;
  logic [7:0]  ien_q, ien_d;
  logic        flag_q, flag_d;
  logic        state_q, state_d;
  logic        prev_q, prev_d;
  logic [31:0] prdata_q, prdata_d;
  logic        pready_q, pready_d;
  logic        pslverr_q, pslverr_d;
  logic        ana_q, ana_d;
  logic        pad_q, pad_d;
  logic        padoe_q, padoe_d;
  logic        event_q, event_d;
  logic        irq_q, irq_d;

  logic        cmp_sync;
  logic        active;
  logic        upd;
  logic        cmp_vis;
  logic        rise;
  logic        fall;
  logic        hit;
  logic [3:0]  dec;
  logic        setup;
  logic        wr_en;
  logic        wr_ctrl, wr_insel, wr_ien, wr_stat;

  ////////////////////////////////////////////////////////////////////////////
  // synchroniser

  // raw output is decided by the analog core, one when positive is higher
  cmpc_sync u_sync
  (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (cmp_raw),
    .sync_out (cmp_sync)
  );

  ////////////////////////////////////////////////////////////////////////////
  // operating state

  // halted when disabled, in power-down, or in standby without standby_run
  assign active = ctrl_q[CTRL_EN] && !powerdown_sleep &&
                  (!standby_sleep || ctrl_q[CTRL_RUNSB]);
  // standby freezes status and flag even while running
  assign upd = active && !standby_sleep;
  // inversion applied before every consumer
  assign cmp_vis = cmp_sync ^ insel_q[INSEL_INV];

  ////////////////////////////////////////////////////////////////////////////
  // apb decode

  assign dec      = cmpc_decode(paddr);
  assign setup    = psel && !penable;
  // write lands only at the edge where pready is seen high
  assign wr_en    = psel && penable && pready_q && pwrite && dec[3] && pstrb[0];
  assign wr_ctrl  = wr_en && dec[2:0] == IDX_CTRL;
  assign wr_insel = wr_en && dec[2:0] == IDX_INSEL;
  assign wr_ien   = wr_en && dec[2:0] == IDX_IEN;
  assign wr_stat  = wr_en && dec[2:0] == IDX_STAT;

  // read data and error are prepared in setup so every output is a flop
  always_comb
  begin
    pready_d  = setup;
    pslverr_d = setup && !dec[3];
    prdata_d  = prdata_q;
    if (setup)
    begin
      prdata_d = 32'h0000_0000;
      if (!pwrite && dec[3])
      begin
        unique case (dec[2:0])
          IDX_CTRL:  prdata_d[7:0] = ctrl_q;
          IDX_INSEL: prdata_d[7:0] = insel_q;
          IDX_IEN:   prdata_d[7:0] = ien_q;
          default:   prdata_d[7:0] = {3'h0, state_q, 3'h0, flag_q};
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers

  // reserved bits are masked so they read as zero
  always_comb
  begin
    ctrl_d  = wr_ctrl  ? (pwdata[7:0] & CTRL_MASK)  : ctrl_q;
    insel_d = wr_insel ? (pwdata[7:0] & INSEL_MASK) : insel_q;
    ien_d   = wr_ien   ? {7'h00, pwdata[IEN_CMP]}   : ien_q;
  end

  ////////////////////////////////////////////////////////////////////////////
  // state, edge detect and flag

  assign rise = cmp_vis && !prev_q;
  assign fall = !cmp_vis && prev_q;
  // edges seen on the synchronised value, never on the raw input
  assign hit  = upd && cmpc_hit(ctrl_q[CTRL_MODE +: 2], rise, fall);

  always_comb
  begin
    state_d = state_q;
    prev_d  = prev_q;
    if (!active)
    begin
      state_d = 1'b0;
      prev_d  = 1'b0;
    end
    else if (upd)
    begin
      state_d = cmp_vis;
      prev_d  = cmp_vis;
    end
    // a new edge wins over a clearing write in the same cycle
    flag_d = flag_q;
    if (wr_stat && pwdata[STAT_FLAG])
      flag_d = 1'b0;
    if (hit)
      flag_d = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs to analog, pad, event and interrupt

  always_comb
  begin
    ana_d   = active;
    padoe_d = active && ctrl_q[CTRL_PAD_OUTPUT_ENABLE];
    pad_d   = active && ctrl_q[CTRL_PAD_OUTPUT_ENABLE] && cmp_vis;
    // events keep following in standby, unlike status
    event_d = active && cmp_vis;
    irq_d   = flag_q && ien_q[IEN_CMP];
  end

  ////////////////////////////////////////////////////////////////////////////
  // flops

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q    <= REG_RESET;
      insel_q   <= REG_RESET;
      ien_q     <= REG_RESET;
      flag_q    <= 1'b0;
      state_q   <= 1'b0;
      prev_q    <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      ana_q     <= 1'b0;
      pad_q     <= 1'b0;
      padoe_q   <= 1'b0;
      event_q   <= 1'b0;
      irq_q     <= 1'b0;
    end
    else
    begin
      ctrl_q    <= ctrl_d;
      insel_q   <= insel_d;
      ien_q     <= ien_d;
      flag_q    <= flag_d;
      state_q   <= state_d;
      prev_q    <= prev_d;
      prdata_q  <= prdata_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
      ana_q     <= ana_d;
      pad_q     <= pad_d;
      padoe_q   <= padoe_d;
      event_q   <= event_d;
      irq_q     <= irq_d;
    end
  end

  // settings go straight to the analog core from their flops
  assign positive_select   = insel_q[INSEL_POS +: 2];
  assign negative_select   = insel_q[INSEL_NEG +: 2];
  assign hysteresis_select = ctrl_q[CTRL_HYS +: 2];
  assign prdata    = prdata_q;
  assign pready    = pready_q;
  assign pslverr   = pslverr_q;
  assign ana_enable = ana_q;
  assign pad_out   = pad_q;
  assign pad_oe    = padoe_q;
  assign event_out = event_q;
  assign irq       = irq_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  chk_state_delay: assert property (
    @(posedge pclk) disable iff (!presetn)
    $past(upd) |-> state_q == ($past(cmp_raw, 3) ^ $past(insel_q[INSEL_INV])))
    else $error("status state does not follow input after three cycles");

  chk_flag_clear: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_stat && pwdata[STAT_FLAG] && !hit |=> !flag_q)
    else $error("flag not cleared by writing one");

  chk_flag_hold: assert property (
    @(posedge pclk) disable iff (!presetn)
    flag_q && !(wr_stat && pwdata[STAT_FLAG]) |=> flag_q)
    else $error("flag lost without a clearing write");

  chk_edge_mode: assert property (
    @(posedge pclk) disable iff (!presetn)
    upd && ctrl_q[CTRL_MODE +: 2] == MODE_RISE && rise ##1 !wr_stat [*2] |-> flag_q)
    else $error("rising edge did not set the flag");

  chk_reserved_mode: assert property (
    @(posedge pclk) disable iff (!presetn)
    ctrl_q[CTRL_MODE +: 2] == MODE_RSVD && !flag_q |=> !flag_q)
    else $error("reserved edge mode set the flag");

  chk_irq_level: assert property (
    @(posedge pclk) disable iff (!presetn)
    ##1 irq_q == ($past(flag_q) && $past(ien_q[IEN_CMP])))
    else $error("irq does not match flag and enable");

  chk_pad_drive: assert property (
    @(posedge pclk) disable iff (!presetn)
    pad_oe |-> $past(ctrl_q[CTRL_PAD_OUTPUT_ENABLE]) && !$past(powerdown_sleep) && pad_out == event_out)
    else $error("pad driven without enable or with wrong value");

  chk_powerdown_off: assert property (
    @(posedge pclk) disable iff (!presetn)
    powerdown_sleep |=> !ana_enable && !pad_oe && !event_out)
    else $error("comparator active in power-down");

  chk_standby_freeze: assert property (
    @(posedge pclk) disable iff (!presetn)
    standby_sleep && !(wr_stat && pwdata[STAT_FLAG]) |=>
      $stable(flag_q) && ($stable(state_q) || !$past(active)))
    else $error("status changed in standby");

  // a halted comparator reads as zero, its state is not kept
  chk_standby_halt: assert property (
    @(posedge pclk) disable iff (!presetn)
    standby_sleep && !ctrl_q[CTRL_RUNSB] |=> !ana_enable && !state_q)
    else $error("comparator not halted in standby");

  chk_apb_ready: assert property (
    @(posedge pclk) disable iff (!presetn)
    psel && !penable |=> pready_q ##1 !pready_q)
    else $error("ready not a single cycle after setup");

  // the event path has the same latency as the status state bit
  chk_event_follow: assert property (
    @(posedge pclk) disable iff (!presetn)
    $past(active) |-> event_out == ($past(cmp_raw, 3) ^ $past(insel_q[INSEL_INV])))
    else $error("event does not follow comparator output");

  chk_irq_enable: assert property (
    @(posedge pclk) disable iff (!presetn)
    !ien_q[IEN_CMP] |=> !irq)
    else $error("irq raised while disabled");

  chk_disable_off: assert property (
    @(posedge pclk) disable iff (!presetn)
    !ctrl_q[CTRL_EN] |=> !ana_enable && !event_out && !pad_oe)
    else $error("comparator active while disabled");

  chk_flag_any: assert property (
    @(posedge pclk) disable iff (!presetn)
    upd && ctrl_q[CTRL_MODE +: 2] == MODE_ANY && (rise || fall) |=> flag_q)
    else $error("edge did not set the flag in any-edge mode");

  chk_flag_fall: assert property (
    @(posedge pclk) disable iff (!presetn)
    upd && ctrl_q[CTRL_MODE +: 2] == MODE_FALL && fall |=> flag_q)
    else $error("falling edge did not set the flag");

endmodule

// ---- cmpc_analog.sv ----
// behavioural analog core: pin, reference and dac levels in, decision out
`timescale 1ns/1ps
module cmpc_analog
(
  // controls from the block
  input  wire logic       ana_enable,
  input  wire logic [1:0] positive_select,
  input  wire logic [1:0] negative_select,
  // levels in millivolts, indexed by the select codes
  input  wire logic [7:0] pos_mv [4],
  input  wire logic [7:0] neg_mv [4],
  // comparator decision
  output logic            cmp_raw
);
  // a powered-down core reads low, it never holds a stale decision
  assign cmp_raw = ana_enable && (pos_mv[positive_select] > neg_mv[negative_select]);
endmodule

// ---- comparator_control_bench.sv ----
// self-checking bench for the comparator control block
`timescale 1ns/1ps
module comparator_control_bench
  import cmpc_pkg::*;
  ;
  // byte addresses, four times the register index
  localparam logic [7:0] A_CTRL  = {3'h0, IDX_CTRL, 2'h0};
  localparam logic [7:0] A_INSEL = {3'h0, IDX_INSEL, 2'h0};
  localparam logic [7:0] A_IEN   = {3'h0, IDX_IEN, 2'h0};
  localparam logic [7:0] A_STAT  = {3'h0, IDX_STAT, 2'h0};
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  pstrb = 4'hF;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        cmp_raw;
  logic        ana_enable;
  logic [1:0]  pos_sel;
  logic [1:0]  neg_sel;
  logic [1:0]  hys_sel;
  logic        standby_sleep = 1'b0;
  logic        powerdown_sleep = 1'b0;
  logic        pad_out;
  logic        pad_oe;
  logic        event_out;
  logic        irq;
  logic [7:0]  pos_mv [4] = '{8'h40, 8'h40, 8'h40, 8'h40};
  logic [7:0]  neg_mv [4] = '{8'h80, 8'h80, 8'h80, 8'h80};
  logic [31:0] rd;
  logic        err;
  logic        fh;
  logic        rh;
  int          n_fail = 0;
  int          compares = 0;
  int          cycles = 0;

  cmpc_top uut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cmp_raw(cmp_raw), .ana_enable(ana_enable), .positive_select(pos_sel),
    .negative_select(neg_sel), .hysteresis_select(hys_sel), .standby_sleep(standby_sleep),
    .powerdown_sleep(powerdown_sleep), .pad_out(pad_out), .pad_oe(pad_oe),
    .event_out(event_out), .irq(irq));
  cmpc_analog core (.ana_enable(ana_enable), .positive_select(pos_sel), .negative_select(neg_sel),
    .pos_mv(pos_mv), .neg_mv(neg_mv), .cmp_raw(cmp_raw));

  // clock and hang guard; a stuck handshake ends the run as a mismatch
  always #20 pclk = ~pclk;
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      n_fail++;
      conclude();
    end
  end

  task automatic conclude;
    if (n_fail == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one apb transfer; answer taken at the edge where pready is sampled high
  // the idle edge at the end keeps two calls from driving psel twice at once
  task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] wd);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, wd};
    pstrb <= 4'h1;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    apb(1'b0, a, 8'h00);
    chk("read data", {24'h0, exp}, rd);
  endtask

  // move the selected positive pin across the threshold, then let sync settle
  task automatic drive_in(input logic hi);
    pos_mv[pos_sel] <= hi ? 8'hC0 : 8'h40;
    repeat (STATE_DELAY + 2) @(posedge pclk);
  endtask

  // main sequence
  initial
  begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rchk(A_CTRL, REG_RESET);
    rchk(A_INSEL, REG_RESET);
    rchk(A_IEN, REG_RESET);
    rchk(A_STAT, REG_RESET);
    apb(1'b1, 8'h04, 8'hFF);
    chk("unmapped error", 32'h1, {31'h0, err});
    rchk(8'h04, 8'h00);
    apb(1'b1, A_INSEL, 8'hFF);
    rchk(A_INSEL, INSEL_MASK);
    chk("select outputs", 32'hF, {28'h0, pos_sel, neg_sel});
    apb(1'b1, A_INSEL, 8'h0A);
    chk("select outputs", 32'h6, {28'h0, pos_sel, neg_sel});
    apb(1'b1, A_CTRL, 8'hFF);
    rchk(A_CTRL, CTRL_MASK);
    chk("hysteresis", 32'h3, {30'h0, hys_sel});
    apb(1'b1, A_CTRL, 8'h40);
    // output flops lag the register write by one edge
    @(posedge pclk);
    chk("disabled core", 32'h0, {30'h0, ana_enable, event_out});
    apb(1'b1, A_STAT, 8'hFF);
    // enabled, any edge, pad on, interrupt enabled
    apb(1'b1, A_CTRL, 8'h41);
    apb(1'b1, A_IEN, 8'h01);
    drive_in(1'b1);
    rchk(A_STAT, 8'h11);
    chk("event pad irq", 32'hF, {28'h0, event_out, pad_out, pad_oe, irq});
    apb(1'b1, A_STAT, 8'h00);
    rchk(A_STAT, 8'h11);
    apb(1'b1, A_STAT, 8'h01);
    rchk(A_STAT, 8'h10);
    chk("irq", 32'h0, {31'h0, irq});
    // inversion feeds state, edge detection and event alike
    apb(1'b1, A_INSEL, 8'h8A);
    repeat (STATE_DELAY + 2) @(posedge pclk);
    rchk(A_STAT, 8'h01);
    chk("inverted event", 32'h0, {31'h0, event_out});
    apb(1'b1, A_INSEL, 8'h0A);
    repeat (STATE_DELAY + 2) @(posedge pclk);
    apb(1'b1, A_STAT, 8'h01);
    // every edge mode, falling then rising edge
    for (int m = 0; m < 4; m++)
    begin
      fh = (m == 0 || m == 2);
      rh = (m == 0 || m == 3);
      apb(1'b1, A_CTRL, {2'h1, m[1:0], 4'h1});
      drive_in(1'b0);
      rchk(A_STAT, {7'h0, fh});
      chk("irq", {31'h0, fh}, {31'h0, irq});
      apb(1'b1, A_STAT, 8'h01);
      drive_in(1'b1);
      rchk(A_STAT, {7'h0, rh} | 8'h10);
      apb(1'b1, A_STAT, 8'h01);
    end
    // a set flag with its enable off raises no request
    apb(1'b1, A_IEN, 8'h00);
    drive_in(1'b0);
    drive_in(1'b1);
    rchk(A_STAT, 8'h11);
    chk("masked irq", 32'h0, {31'h0, irq});
    apb(1'b1, A_IEN, 8'h01);
    @(posedge pclk);
    chk("unmasked irq", 32'h1, {31'h0, irq});
    apb(1'b1, A_STAT, 8'h01);
    // standby: halted unless standby_run, then flags frozen
    standby_sleep <= 1'b1;
    repeat (STATE_DELAY + 2) @(posedge pclk);
    chk("standby halt", 32'h0, {30'h0, ana_enable, event_out});
    apb(1'b1, A_CTRL, 8'hC1);
    drive_in(1'b0);
    drive_in(1'b1);
    chk("standby event", 32'h3, {30'h0, event_out, pad_out});
    apb(1'b0, A_STAT, 8'h00);
    chk("standby status", 32'h0, rd);
    powerdown_sleep <= 1'b1;
    repeat (STATE_DELAY + 2) @(posedge pclk);
    chk("powerdown", 32'h0, {29'h0, ana_enable, pad_oe, event_out});
    conclude();
  end
endmodule
